// ===== pkg/xfer_pkg.sv
/*
 * Shared constants and carrier types of the shared-memory DMA controller.
 * Assumes a single 100 MHz clock domain and a synchronous reset.
 */
`default_nettype none

package xfer_pkg;

  localparam int MEM_WORDS = 4096;
  localparam int WADDR_W = 12;
  localparam int CNT_W = 13;

  localparam logic [2:0] SEL_LOCAL_BASE = 3'h0;
  localparam logic [2:0] SEL_HOST_BASE = 3'h1;
  localparam logic [2:0] SEL_LENGTH = 3'h2;
  localparam logic [2:0] SEL_CONTROL = 3'h3;
  localparam logic [2:0] SEL_LOCAL_IRQ_STATUS_MASK = 3'h4;

  localparam int CTL_DIR_BIT = 0;
  localparam int CTL_LOCAL_OWN_BIT = 1;
  localparam int CTL_PCI_OWN_BIT = 2;
  localparam int CTL_NO_PREFETCH_BIT = 3;

  localparam int LOCAL_IRQ_STATUS_MASK_DONE_BIT = 5;
  localparam int LOCAL_IRQ_STATUS_MASK_DONE_EN_BIT = 21;

  localparam int ADDR_LSB = 2;
  localparam int LEN_MSB = 14;

  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] BE_ALL_N = 4'h0;

  localparam logic [31:0] RESET_WORD = 32'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0;
  localparam logic [31:0] HOST_STEP = 32'h4;

  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [3:0] be;
    logic [31:0] data;
  } cfg_wr_t;

  typedef struct packed {
    logic [31:0] local_base;
    logic [31:0] host_base;
    logic [31:0] length;
    logic [31:0] control;
    logic [31:0] local_irq_status_mask;
  } cfg_view_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be_n;
    logic [31:0] wdata;
    logic last;
  } mst_out_t;

  typedef struct packed {
    logic ack;
    logic stop;
    logic [31:0] rdata;
  } mst_in_t;

endpackage : xfer_pkg

`default_nettype wire

// ===== hdl/shared_mem.sv
/*
 * Dual-port shared memory of 16 KB, one DWORD per word.
 * Assumes both ports run on the same clock; the transfer port reads
 * combinationally, the target port reads through a register.
 */
`default_nettype none

module shared_mem (
  input wire logic clk,
  input wire logic [xfer_pkg::WADDR_W-1:0] dma_addr,
  input wire logic dma_we,
  input wire logic [31:0] dma_wdata,
  output logic [31:0] dma_rdata,
  input wire logic [xfer_pkg::WADDR_W-1:0] tgt_addr,
  input wire logic tgt_we,
  input wire logic [31:0] tgt_wdata,
  output logic [31:0] tgt_rdata
);
  import xfer_pkg::*;

  logic [31:0] mem [MEM_WORDS];

  assign dma_rdata = mem[dma_addr];

  // On a same-word collision the transfer engine's write lands last.
  always_ff @(posedge clk) begin
    if (tgt_we) begin
      mem[tgt_addr] <= tgt_wdata;
    end
    if (dma_we) begin
      mem[dma_addr] <= dma_wdata;
    end
    tgt_rdata <= mem[tgt_addr];
  end

endmodule : shared_mem

`default_nettype wire

// ===== hdl/xfer_engine.sv
/*
 * Bus-mastering transfer controller between the shared memory and the
 * 32-bit PCI space, with its setup registers and completion flag.
 * Assumes a PCI master sequencer on the same clock that turns the burst
 * request into bus cycles, pulses ack per completed data phase and stop
 * when the burst was terminated early.
 */
`default_nettype none

// Contract
// - Bursts move data between the 16 KB shared memory and PCI space.
// - Setup registers are writable from both the PCI and local ports.
// - Completion shows in a polled status bit and an enabled interrupt.
// - Control holds a local and a PCI ownership flag for software.
// - Address and length fields ignore their two lowest bits.
// - Every mastered data phase carries all four byte enables.
// - PCI addresses span 32 bits starting from the host base register.
// - Control bit 0 high writes memory to PCI, low reads PCI to memory.
// - A write to the control low byte while idle starts with that write's direction.
// - Each burst uses the most efficient command for its direction; reads with the no-prefetch flag set use plain memory read instead.
// - Completion sets status bit 5; the interrupt needs the mask.
// - Mask bit 21 high drives a pending completion onto the irq pin.
// - The no-prefetch flag selects plain memory reads for inbound moves.
module xfer_engine (
  input wire logic clk,
  input wire logic srst,
  input wire xfer_pkg::cfg_wr_t pci_wr,
  input wire xfer_pkg::cfg_wr_t local_wr,
  output xfer_pkg::cfg_view_t cfg_view,
  output logic busy,
  output logic done_flag,
  output logic irq_pin_o,
  output logic irq_pin_oe_n,
  output xfer_pkg::mst_out_t mst_out,
  input wire xfer_pkg::mst_in_t mst_in,
  input wire logic [xfer_pkg::WADDR_W-1:0] tgt_addr,
  input wire logic tgt_we,
  input wire logic [31:0] tgt_wdata,
  output logic [31:0] tgt_rdata
);
  import xfer_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_GAP, ST_DONE} state_t;

  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input cfg_wr_t wr);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (wr.be[i]) begin
        res[i*8 +: 8] = wr.data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic hits(input cfg_wr_t wr, input logic [2:0] sel);
    return wr.en && (wr.sel == sel);
  endfunction : hits

  state_t state_reg, state_next;
  logic [31:0] lbase_reg, hbase_reg, len_reg, ctl_reg, local_irq_status_mask_reg;
  logic [31:0] lbase_next, hbase_next, len_next, ctl_next, local_irq_status_mask_next;
  logic [31:0] haddr_reg, haddr_next;
  logic [WADDR_W-1:0] laddr_reg, laddr_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic dir_reg, dir_next;
  logic [31:0] wdata_reg, wdata_next;

  // Local side wins a same-cycle collision on a register: the PCI write is dropped.
  assign lbase_next = hits(local_wr, SEL_LOCAL_BASE) ? merge(lbase_reg,
    local_wr) : (hits(pci_wr, SEL_LOCAL_BASE) ? merge(lbase_reg, pci_wr)
    : lbase_reg);
  assign hbase_next = hits(local_wr, SEL_HOST_BASE) ? merge(hbase_reg,
    local_wr) : (hits(pci_wr, SEL_HOST_BASE) ? merge(hbase_reg, pci_wr)
    : hbase_reg);
  assign len_next = hits(local_wr, SEL_LENGTH) ? merge(len_reg, local_wr)
    : (hits(pci_wr, SEL_LENGTH) ? merge(len_reg, pci_wr) : len_reg);
  assign ctl_next = hits(local_wr, SEL_CONTROL) ? merge(ctl_reg, local_wr)
    : (hits(pci_wr, SEL_CONTROL) ? merge(ctl_reg, pci_wr) : ctl_reg);

  wire start_pci = hits(pci_wr, SEL_CONTROL) && pci_wr.be[0];
  wire start_local = hits(local_wr, SEL_CONTROL) && local_wr.be[0];
  wire start_req = start_pci || start_local;
  wire start_ok = start_req && (state_reg == ST_IDLE);
  wire start_dir = start_local ? local_wr.data[CTL_DIR_BIT]
                               : pci_wr.data[CTL_DIR_BIT];
  wire [CNT_W-1:0] start_cnt = len_next[LEN_MSB:ADDR_LSB];
  wire [WADDR_W-1:0] start_laddr =
    lbase_next[WADDR_W+ADDR_LSB-1:ADDR_LSB];
  wire [31:0] start_haddr = {hbase_next[31:ADDR_LSB], 2'b00};

  wire phase_ok = (state_reg == ST_BURST) && mst_in.ack;
  wire last_phase = phase_ok && (cnt_reg == CNT_ONE);
  wire set_done = (state_reg == ST_DONE);

  // Completion status is write-one-to-clear; a completion in the clearing
  // cycle survives because the set is applied after the clear.
  logic [31:0] local_irq_status_mask_wr;
  assign local_irq_status_mask_wr = hits(local_wr, SEL_LOCAL_IRQ_STATUS_MASK) ? merge(local_irq_status_mask_reg, local_wr)
    : (hits(pci_wr, SEL_LOCAL_IRQ_STATUS_MASK) ? merge(local_irq_status_mask_reg, pci_wr) : local_irq_status_mask_reg);
  wire clr_done = (hits(local_wr, SEL_LOCAL_IRQ_STATUS_MASK) && local_wr.be[0]
    && local_wr.data[LOCAL_IRQ_STATUS_MASK_DONE_BIT]) || (hits(pci_wr, SEL_LOCAL_IRQ_STATUS_MASK)
    && pci_wr.be[0] && pci_wr.data[LOCAL_IRQ_STATUS_MASK_DONE_BIT]);
  always_comb begin
    local_irq_status_mask_next = local_irq_status_mask_wr;
    local_irq_status_mask_next[LOCAL_IRQ_STATUS_MASK_DONE_BIT] = set_done
      || (local_irq_status_mask_reg[LOCAL_IRQ_STATUS_MASK_DONE_BIT] && !clr_done);
  end

  wire [WADDR_W-1:0] laddr_inc = laddr_reg + 12'h1;
  wire [31:0] mem_rdata;
  wire [WADDR_W-1:0] mem_addr = start_ok ? start_laddr
    : ((phase_ok && dir_reg) ? laddr_inc : laddr_reg);
  wire mem_we = phase_ok && !dir_reg;

  shared_mem u_mem (
    .clk(clk),
    .dma_addr(mem_addr),
    .dma_we(mem_we),
    .dma_wdata(mst_in.rdata),
    .dma_rdata(mem_rdata),
    .tgt_addr(tgt_addr),
    .tgt_we(tgt_we),
    .tgt_wdata(tgt_wdata),
    .tgt_rdata(tgt_rdata)
  );

  always_comb begin
    state_next = state_reg;
    haddr_next = haddr_reg;
    laddr_next = laddr_reg;
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    wdata_next = wdata_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok) begin
          dir_next = start_dir;
          haddr_next = start_haddr;
          laddr_next = start_laddr;
          cnt_next = start_cnt;
          wdata_next = mem_rdata;
          state_next = (start_cnt == CNT_ZERO) ? ST_DONE : ST_BURST;
        end
      end
      ST_BURST: begin
        if (phase_ok) begin
          haddr_next = haddr_reg + HOST_STEP;
          laddr_next = laddr_inc;
          cnt_next = cnt_reg - CNT_ONE;
          wdata_next = mem_rdata;
        end
        if (last_phase) begin
          state_next = ST_DONE;
        end else if (mst_in.stop) begin
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        state_next = ST_BURST;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      lbase_reg <= RESET_WORD;
      hbase_reg <= RESET_WORD;
      len_reg <= RESET_WORD;
      ctl_reg <= RESET_WORD;
      local_irq_status_mask_reg <= RESET_WORD;
      haddr_reg <= RESET_WORD;
      laddr_reg <= '0;
      cnt_reg <= CNT_ZERO;
      dir_reg <= 1'b0;
      wdata_reg <= RESET_WORD;
    end else begin
      state_reg <= state_next;
      lbase_reg <= lbase_next;
      hbase_reg <= hbase_next;
      len_reg <= len_next;
      ctl_reg <= ctl_next;
      local_irq_status_mask_reg <= local_irq_status_mask_next;
      haddr_reg <= haddr_next;
      laddr_reg <= laddr_next;
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      wdata_reg <= wdata_next;
    end
  end

  // Write bursts use plain memory write; reads prefer read-multiple unless
  // the target's space must not be prefetched.
  wire [3:0] burst_cmd = dir_reg ? CMD_MEM_WRITE
    : (ctl_reg[CTL_NO_PREFETCH_BIT] ? CMD_MEM_READ
    : CMD_MEM_READ_MULT);

  assign mst_out.req = (state_reg == ST_BURST);
  assign mst_out.addr = haddr_reg;
  assign mst_out.cmd = burst_cmd;
  assign mst_out.be_n = BE_ALL_N;
  assign mst_out.wdata = wdata_reg;
  assign mst_out.last = (cnt_reg == CNT_ONE);

  assign cfg_view.local_base = lbase_reg;
  assign cfg_view.host_base = hbase_reg;
  assign cfg_view.length = len_reg;
  assign cfg_view.control = ctl_reg;
  assign cfg_view.local_irq_status_mask = local_irq_status_mask_reg;
  assign busy = (state_reg != ST_IDLE);
  assign done_flag = local_irq_status_mask_reg[LOCAL_IRQ_STATUS_MASK_DONE_BIT];

  wire irq_active = local_irq_status_mask_reg[LOCAL_IRQ_STATUS_MASK_DONE_BIT]
    && local_irq_status_mask_reg[LOCAL_IRQ_STATUS_MASK_DONE_EN_BIT];
  assign irq_pin_o = 1'b0;
  assign irq_pin_oe_n = !irq_active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_full_byte_enables: assert property (
    mst_out.req |-> mst_out.be_n == 4'h0)
    else $error("Data phase without all byte enables.");

  a_read_command: assert property (
    mst_out.req && !dir_reg && ctl_reg[CTL_NO_PREFETCH_BIT]
    |-> mst_out.cmd == 4'h6)
    else $error("Non-prefetch read used a prefetching command.");

  a_burst_command: assert property (
    mst_out.req |-> (dir_reg ? mst_out.cmd == 4'h7
    : (ctl_reg[CTL_NO_PREFETCH_BIT] || mst_out.cmd == 4'hc)))
    else $error("Burst command does not fit the direction.");

  a_start_ignored: assert property (
    busy && start_req |=> dir_reg == $past(dir_reg)
    && cnt_reg <= $past(cnt_reg))
    else $error("Start taken while a transfer was running.");

  a_start_direction: assert property (
    !busy && start_req && len_next[LEN_MSB:ADDR_LSB] != 13'h0
    |=> busy && dir_reg == $past(start_dir)
    && mst_out.addr[1:0] == 2'b00)
    else $error("Start did not load the written direction.");

  a_addr_step: assert property (
    phase_ok && !last_phase |=> mst_out.addr == $past(mst_out.addr) + 32'h4)
    else $error("Host address did not advance by one DWORD.");

  a_done_sets: assert property (
    last_phase |-> ##2 done_flag)
    else $error("Completion did not set the status bit.");

  a_irq_mask: assert property (
    irq_pin_oe_n == !(local_irq_status_mask_reg[5] && local_irq_status_mask_reg[21]))
    else $error("Interrupt pin disagrees with status and mask.");

  a_done_idle: assert property (
    $rose(done_flag) |-> !busy && $past(state_reg) == ST_DONE)
    else $error("Status bit rose without a completed transfer.");

endmodule : xfer_engine

`default_nettype wire

// ===== dv/pci_target_model.sv
/*
 * Behavioural PCI target for the burst port: acks, stalls and stops.
 * Assumes the engine holds req, addr and wdata steady until acked.
 */
`default_nettype none

module pci_target_model
  import xfer_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic stop_en,
  input wire xfer_pkg::mst_out_t mo,
  output xfer_pkg::mst_in_t mi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack_reg = 1'b0;
  logic go = 1'b1;
  wire logic [31:0] word = mo.addr ^ 32'h5a5a_a5a5;
  wire logic stop_hit = ack_reg && stop_en && mo.addr[3:2] == 2'h1;
  // A last or stopped phase is never acked twice.
  wire logic ack_next = mo.req && (go || !slow)
    && !(ack_reg && (mo.last || stop_hit));
  always @(posedge clk) begin
    go <= 1'($urandom_range(1, 0));
    ack_reg <= !srst && ack_next;
  end
  // Idle data is inverted so that a late sample never matches by luck.
  assign mi = '{ack_reg, stop_hit, ack_reg ? word : ~word};
endmodule : pci_target_model

`default_nettype wire

// ===== dv/tb.sv
/*
 * Self-checking bench of the transfer engine with a PCI target model.
 * Assumes a 100 MHz clock and the engine's synchronous reset.
 */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import xfer_pkg::*;
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0] c;
  } exp_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic stp = 1'b0;
  logic tgt_we = 1'b0;
  logic [WADDR_W-1:0] tgt_addr = '0;
  logic [31:0] tgt_wdata = '0;
  logic [31:0] tgt_rdata;
  cfg_wr_t lw = '0;
  cfg_wr_t pw = '0;
  cfg_view_t view;
  mst_out_t mo;
  mst_in_t mi;
  logic busy, done_flag, irq_o, irq_oe_n;
  wire logic irq_line = irq_oe_n ? 1'b1 : irq_o;
  logic [31:0] smem [MEM_WORDS];
  exp_t expq [$];
  int num_errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  xfer_engine uut (.clk(clk), .srst(srst), .pci_wr(pw), .local_wr(lw),
    .cfg_view(view), .busy(busy), .done_flag(done_flag),
    .irq_pin_o(irq_o), .irq_pin_oe_n(irq_oe_n), .mst_out(mo), .mst_in(mi),
    .tgt_addr(tgt_addr), .tgt_we(tgt_we), .tgt_wdata(tgt_wdata),
    .tgt_rdata(tgt_rdata));
  pci_target_model far (.clk(clk), .srst(srst), .slow(slow),
    .stop_en(stp), .mo(mo), .mi(mi));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input bit port, input logic [2:0] sel,
                    input logic [3:0] be, input logic [31:0] d);
    if (port) pw = '{1'b1, sel, be, d};
    else lw = '{1'b1, sel, be, d};
    @(posedge clk);
    #1;
    pw.en = 1'b0;
    lw.en = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  always @(posedge clk) begin
    exp_t e;
    if (!srst && mo.req && mi.ack) begin
      if (expq.size() == 0) begin
        chk("extra phase", 32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        chk("addr", mo.addr, e.a);
        chk("cmd", 32'(mo.cmd), 32'(e.c));
        chk("byte enables", 32'(mo.be_n), 32'(BE_ALL_N));
        chk("last", 32'(mo.last), 32'(expq.size() == 0));
        if (e.c == CMD_MEM_WRITE) chk("wdata", mo.wdata, e.d);
      end
    end
  end

  task automatic xfer(input bit port, input bit dir, input bit npf,
    input logic [31:0] lb, input logic [31:0] hb, input int nw,
    input bit sl, input bit st, input bit mask);
    logic [31:0] ha;
    logic [3:0] c;
    int idx;
    exp_t e;
    slow = sl;
    stp = st;
    ha = {hb[31:2], 2'b00};
    c = dir ? CMD_MEM_WRITE : (npf ? CMD_MEM_READ : CMD_MEM_READ_MULT);
    wr(port, SEL_LOCAL_IRQ_STATUS_MASK, 4'hf, 32'(mask) << LOCAL_IRQ_STATUS_MASK_DONE_EN_BIT);
    wr(port, SEL_LOCAL_BASE, 4'hf, lb);
    wr(!port, SEL_HOST_BASE, 4'hf, hb);
    wr(port, SEL_LENGTH, 4'hf, 32'(nw * 4 + 3));
    chk("local base", view.local_base, lb);
    chk("host base", view.host_base, hb);
    chk("length", view.length, 32'(nw * 4 + 3));
    for (int i = 0; i < nw; i++) begin
      idx = (int'(lb[13:2]) + i) % MEM_WORDS;
      e = '{ha + 32'(4 * i), smem[idx], c};
      expq.push_back(e);
    end
    wr(port, SEL_CONTROL, 4'h1, {28'h0, npf, 2'b11, dir});
    if (nw > 3) wr(!port, SEL_CONTROL, 4'h1, {28'h0, npf, 2'b11, dir});
    for (int i = 0; i < 6000 && !done_flag; i++) @(posedge clk);
    #1;
    chk("busy", 32'(busy), 32'h0);
    chk("done bit", 32'(view.local_irq_status_mask[LOCAL_IRQ_STATUS_MASK_DONE_BIT]), 32'h1);
    chk("irq line", 32'(irq_line), 32'(!mask));
    chk("pending phases", 32'(expq.size()), 32'h0);
    chk("owner flags", 32'(view.control[2:1]), 32'h3);
    for (int i = 0; i < nw && !dir; i++) begin
      idx = (int'(lb[13:2]) + i) % MEM_WORDS;
      smem[idx] = (ha + 32'(4 * i)) ^ 32'h5a5a_a5a5;
      tgt_addr = WADDR_W'(idx);
      @(posedge clk);
      #1;
      chk("read word", tgt_rdata, smem[idx]);
    end
    wr(port, SEL_LOCAL_IRQ_STATUS_MASK, 4'h1, 32'h20);
    chk("done cleared", 32'(done_flag), 32'h0);
    chk("irq released", 32'(irq_line), 32'h1);
  endtask : xfer

  initial begin
    void'($urandom(11));
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    tgt_we = 1'b1;
    for (int i = 0; i < MEM_WORDS; i++) begin
      tgt_addr = WADDR_W'(i);
      tgt_wdata = $urandom;
      smem[i] = tgt_wdata;
      @(posedge clk);
      #1;
    end
    tgt_we = 1'b0;
    xfer(0, 1, 0, 32'h3ffb, 32'hffff_fff1, 4, 0, 0, 1);
    xfer(1, 0, 0, 32'h102, 32'h2000_0000, 8, 1, 1, 0);
    xfer(0, 0, 1, $urandom, $urandom, 5, 0, 1, 1);
    xfer(1, 1, 0, $urandom, $urandom, 9, 1, 1, 0);
    xfer(0, 1, 0, 32'h0, 32'h40, 0, 0, 0, 1);
    xfer(1, 1, 0, 32'h10, $urandom, 4096, 0, 0, 1);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : tb

`default_nettype wire
